// [dv/scc_checker_monitor.sv]
`timescale 1ns/1ps
module scc_chk_mon (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        s_axi_bvalid,
    input wire logic        pll_lock_in,
    input wire logic        synth_enable,
    input wire logic        synth_retune,
    input wire logic [31:0] synth_freq_hz,
    input wire logic [1:0]  trx_state,
    input wire logic        ready_irq,
    input wire logic        error_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_OFF_DISABLED: assert property ($past(trx_state) == 2'h0 |-> !synth_enable)
        else $error("synth enabled in idle");
    AST_QUIET_OFF: assert property (!synth_enable && !$past(synth_enable)
        |-> !ready_irq && !error_irq) else $error("event while synth off");
    AST_ERR_CAUSE: assert property (error_irq |-> !$past(pll_lock_in))
        else $error("error event without lock loss");
    AST_ERR_KEEPS_STATE: assert property (error_irq |-> $stable(trx_state))
        else $error("state moved on error event");
    AST_RDY_CAUSE: assert property (ready_irq |-> $past(pll_lock_in) && synth_enable)
        else $error("ready event without lock");
    AST_RETUNE_ENTRY: assert property ($rose(synth_enable) |-> ##[0:1] synth_retune)
        else $error("no retune on entry");
    // settling may not be skipped, even when lock is already high
    AST_SETTLE_GAP: assert property (synth_retune |=> !ready_irq [*3])
        else $error("ready event before settling");
    AST_FREQ_ON_COMMIT: assert property ($changed(synth_freq_hz)
        |-> $past(s_axi_bvalid))
        else $error("frequency changed without commit");
endmodule : scc_chk_mon

bind scc_synth_channel_config scc_chk_mon mon_u (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .s_axi_bvalid  (s_axi_bvalid),
    .pll_lock_in   (pll_lock_in),
    .synth_enable  (synth_enable),
    .synth_retune  (synth_retune),
    .synth_freq_hz (synth_freq_hz),
    .trx_state     (trx_state),
    .ready_irq     (ready_irq),
    .error_irq     (error_irq)
);

// [dv/tb.sv]
`timescale 1ns/1ps
`include "scc_params.svh"
module tb;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0;
    logic [2:0]  s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1;
    logic        pll_lock_in = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        synth_enable, synth_retune, ready_irq, error_irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, trx_state;
    logic [31:0] s_axi_rdata, synth_freq_hz, ef;
    logic [33:0] q_rd[$];
    logic [1:0]  q_b[$];
    logic [1:0]  q_irq[$];
    logic [7:0]  sp, bl, bh, cl;
    logic        ms;
    int          fails = 0;
    int          n_tests = 0;
    // short counts keep the run brief
    scc_synth_channel_config #(.SETTLE_CYC(4), .BLANK_CYC(2)) dut_u (.*);
    always #20 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // any event not announced pops an empty note and mismatches
    always @(posedge clk_sys) begin
        if (s_axi_rvalid === 1'b1) chk("rdata", q_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid === 1'b1) chk("bresp", q_b.pop_front(), s_axi_bresp);
        if ((ready_irq | error_irq) !== 1'b0) chk("irq", q_irq.pop_front(), {ready_irq, error_irq});
    end
    function automatic logic [33:0] ok(input logic [7:0] v);
        return {26'h0, v};
    endfunction : ok
    function automatic logic [31:0] exp_f(input int s);
        logic [63:0] f;
        if (s == 1) f = `SCC_FINE1_BASE_HZ + ((`SCC_FINE1_REF_HZ * {bh, bl, cl}) >> 16);
        else if (s == 2) f = `SCC_FINE2_BASE_HZ + ((`SCC_FINE2_REF_HZ * {bh, bl, cl}) >> 16);
        else f = ({bh, bl} + {ms, cl} * sp) * `SCC_STEP_HZ;
        return f[31:0];
    endfunction : exp_f
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        q_b.push_back(r);
        s_axi_awaddr  <= a;
        s_axi_awprot  <= 3'($urandom);
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        q_rd.push_back(e);
        s_axi_araddr  <= a;
        s_axi_arprot  <= 3'($urandom);
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
    endtask : rd
    task automatic test_done();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (4000) @(posedge clk_sys);
        fails++;
        test_done();
    end
    initial begin
        void'($urandom(19787));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(`SCC_OFS_SPACING, ok(8'h08));
        rd(`SCC_OFS_BASE_LOW, ok(8'hF8));
        rd(`SCC_OFS_BASE_HIGH, ok(8'h8C));
        rd(`SCC_OFS_CHAN_LOW, ok(8'h00));
        rd(`SCC_OFS_MODE_APPLY, ok(8'h00));
        rd(`SCC_OFS_SYNTH_STAT, ok(8'h00));
        rd(8'h1C, {2'b10, 32'h0});
        ef = 902200000;
        chk("freq", ef, synth_freq_hz);
        for (int s = 0; s < 4; s++) begin
            sp = $urandom;
            bl = $urandom;
            cl = $urandom;
            ms = $urandom;
            bh = 8'h02 + 8'($urandom % 18);
            wr(`SCC_OFS_SPACING, {24'h0, sp}, 2'b00);
            wr(`SCC_OFS_BASE_LOW, {24'h0, bl}, 2'b00);
            wr(`SCC_OFS_BASE_HIGH, {24'h0, bh}, 2'b00);
            wr(`SCC_OFS_CHAN_LOW, {24'h0, cl}, 2'b00);
            rd(`SCC_OFS_BASE_LOW, ok(bl));
            rd(`SCC_OFS_CHAN_LOW, ok(cl));
            chk("freq", ef, synth_freq_hz);
            wr(`SCC_OFS_MODE_APPLY, {24'h0, 2'(s), 5'h1F, ms}, 2'b00);
            rd(`SCC_OFS_MODE_APPLY, ok({2'(s), 5'h0, ms}));
            ef = exp_f(s);
            chk("freq", ef, synth_freq_hz);
        end
        s_axi_wstrb <= 4'h0;
        wr(`SCC_OFS_MODE_APPLY, 32'h41, 2'b00);
        s_axi_wstrb <= 4'hF;
        rd(`SCC_OFS_MODE_APPLY, ok({2'h3, 5'h0, ms}));
        pll_lock_in <= 1'b1;
        q_irq.push_back(2'b10);
        wr(`SCC_OFS_TRX_CTRL, 32'h1, 2'b00);
        repeat (14) @(posedge clk_sys);
        rd(`SCC_OFS_SYNTH_STAT, ok(8'h02));
        q_irq.push_back(2'b01);
        q_irq.push_back(2'b10);
        pll_lock_in <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("state", 2'h1, trx_state);
        pll_lock_in <= 1'b1;
        repeat (3) @(posedge clk_sys);
        q_irq.push_back(2'b10);
        ms = 1'b0;
        ef = exp_f(0);
        wr(`SCC_OFS_MODE_APPLY, 32'h0, 2'b00);
        repeat (14) @(posedge clk_sys);
        chk("freq", ef, synth_freq_hz);
        wr(`SCC_OFS_TRX_CTRL, 32'h0, 2'b00);
        repeat (4) @(posedge clk_sys);
        rd(`SCC_OFS_SYNTH_STAT, ok(8'h00));
        q_irq.push_back(2'b10);
        wr(`SCC_OFS_TRX_CTRL, 32'h3, 2'b00);
        repeat (14) @(posedge clk_sys);
        chk("pending", 34'h0, 34'(q_irq.size() + q_b.size() + q_rd.size()));
        test_done();
    end
endmodule : tb

// [rtl/scc_params.svh]
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// register byte offsets
`define SCC_OFS_SPACING      8'h00
`define SCC_OFS_BASE_LOW     8'h04
`define SCC_OFS_BASE_HIGH    8'h08
`define SCC_OFS_CHAN_LOW     8'h0C
`define SCC_OFS_MODE_APPLY   8'h10
`define SCC_OFS_SYNTH_STAT   8'h14
`define SCC_OFS_TRX_CTRL     8'h18

// field positions
`define SCC_MODE_SCHEME_HI   7
`define SCC_MODE_SCHEME_LO   6
`define SCC_MODE_MSB_BIT     0
`define SCC_STAT_LOCK_BIT    1
`define SCC_STAT_BUSY_BIT    0
`define SCC_TRX_STATE_HI     1

// reset values
`define SCC_RST_SPACING      8'h08
`define SCC_RST_BASE_LOW     8'hF8
`define SCC_RST_BASE_HIGH    8'h8C
`define SCC_RST_CHAN_LOW     8'h00
`define SCC_RST_MODE_APPLY   8'h00

// frequency arithmetic, in hertz
`define SCC_STEP_HZ          64'd25000
`define SCC_OFFSET_24G_HZ    64'd1500000000
`define SCC_FINE1_BASE_HZ    64'd377000000
`define SCC_FINE1_REF_HZ     64'd6500000
`define SCC_FINE2_BASE_HZ    64'd754000000
`define SCC_FINE2_REF_HZ     64'd13000000
`define SCC_FINE3_BASE_HZ    64'd2366000000
`define SCC_FINE3_REF_HZ     64'd26000000
`define SCC_FINE_SHIFT       16

// timing
`define SCC_CLK_KHZ          25000
`define SCC_SETTLE_NS        10000
`define SCC_BLANK_NS         200
`define SCC_SETTLE_CYC       ((`SCC_SETTLE_NS * `SCC_CLK_KHZ + 999999) / 1000000)
`define SCC_BLANK_CYC        ((`SCC_BLANK_NS * `SCC_CLK_KHZ + 999999) / 1000000)

`endif

// [rtl/scc_pkg.sv]
package scc_pkg;

    typedef enum logic [1:0] {
        SCC_TRX_IDLE_OFF   = 2'b00,
        SCC_TRX_TX_PREPARE = 2'b01,
        SCC_TRX_TX         = 2'b10,
        SCC_TRX_RX         = 2'b11
    } scc_trx_state_t;

    typedef enum logic [1:0] {
        SCC_LK_OFF      = 2'b00,
        SCC_LK_TUNING   = 2'b01,
        SCC_LK_LOCKED   = 2'b10,
        SCC_LK_UNLOCKED = 2'b11
    } scc_lock_state_t;

    typedef struct packed {
        logic [1:0] scheme;
        logic       chan_msb;
        logic [7:0] chan_low;
        logic [7:0] base_high;
        logic [7:0] base_low;
        logic [7:0] spacing;
    } scc_chan_cfg_t;

    typedef enum logic [2:0] {
        SCC_SEL_SPACING    = 3'h0,
        SCC_SEL_BASE_LOW   = 3'h1,
        SCC_SEL_BASE_HIGH  = 3'h2,
        SCC_SEL_CHAN_LOW   = 3'h3,
        SCC_SEL_MODE_APPLY = 3'h4,
        SCC_SEL_SYNTH_STAT = 3'h5,
        SCC_SEL_TRX_CTRL   = 3'h6,
        SCC_SEL_NONE       = 3'h7
    } scc_reg_sel_t;

endpackage : scc_pkg

// [rtl/scc_synth_channel_config.sv]
`timescale 1ns/1ps
`include "scc_params.svh"

// Functional notes
// - synthesizer enabled only in tx_prepare, transmit or receive states
// - entering tx_prepare from idle_off raises ready_irq after lock and settling
// - commit while in tx_prepare retunes, ready_irq once relocked
// - lock loss raises error_irq; transceiver state untouched
// - lock regained by itself raises ready_irq again
// - idle_off then back to an active state forces a fresh tuning cycle
// - lock_status_bit shows the lock condition in active states, one cycle late, and reads 0 in idle_off
// - channel registers only stage; mode_apply write commits them all at once
// - scheme 0: (base + index * spacing) * 25kHz plus band offset
// - base_frequency_word 16 bits: high register high byte, low register low byte
// - channel_index 9 bits: channel_low bits 7:0, channel_number_msb on top
// - spacing_word is 8-bit unsigned in 25kHz steps
// - band offset zero for sub-GHz, 1.5GHz for the 2.4GHz band
// - scheme 1 sub-GHz: 377MHz plus 6.5MHz * N / 65536, N 24 bits
// - scheme 2 sub-GHz: 754MHz plus 13MHz * N / 65536; ignored on 2.4GHz
// - scheme 3 2.4GHz: 2366MHz plus 26MHz * N / 65536; ignored on sub-GHz
// - reset: base high 0x8C, base low 0xF8, spacing 200kHz, index zero
// - mode_apply: scheme in bits 7:6, msb in bit 0, rest read zero
// - lock_status_bit is bit 1 of status register, 1 when locked
module scc_synth_channel_config
    import scc_pkg::*;
#(
    parameter int ADDR_W     = 8,
    parameter bit BAND_24G   = 1'b0,
    parameter int SETTLE_CYC = `SCC_SETTLE_CYC,
    parameter int BLANK_CYC  = `SCC_BLANK_CYC,
    parameter int CNT_W      = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              pll_lock_in,
    output logic                   synth_enable,
    output logic                   synth_retune,
    output logic [31:0]            synth_freq_hz,
    output logic [1:0]             trx_state,
    output logic                   ready_irq,
    output logic                   error_irq
);

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    if (SETTLE_CYC < 1 || BLANK_CYC < 1 || ADDR_W < 5 || ADDR_W > 32 || CNT_W > 30
        || SETTLE_CYC >= (1 << CNT_W) || BLANK_CYC >= (1 << CNT_W)) begin : g_bad_param
        $error("scc_synth_channel_config: bad parameter value");
    end

    function automatic scc_reg_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] a8;
        a8 = 8'(addr);
        if (addr[ADDR_W-1:0] != ADDR_W'(a8)) begin
            return SCC_SEL_NONE;
        end
        case (a8)
            `SCC_OFS_SPACING:    return SCC_SEL_SPACING;
            `SCC_OFS_BASE_LOW:   return SCC_SEL_BASE_LOW;
            `SCC_OFS_BASE_HIGH:  return SCC_SEL_BASE_HIGH;
            `SCC_OFS_CHAN_LOW:   return SCC_SEL_CHAN_LOW;
            `SCC_OFS_MODE_APPLY: return SCC_SEL_MODE_APPLY;
            `SCC_OFS_SYNTH_STAT: return SCC_SEL_SYNTH_STAT;
            `SCC_OFS_TRX_CTRL:   return SCC_SEL_TRX_CTRL;
            default:             return SCC_SEL_NONE;
        endcase
    endfunction : reg_decode

    // fine schemes are bounded to the band they belong to; a mismatched
    // scheme falls back to the 25kHz grid, no range check is done
    function automatic logic [31:0] chan_freq(input scc_chan_cfg_t cfg);
        logic [63:0] base_word;
        logic [63:0] index;
        logic [63:0] fine_n;
        logic [63:0] hz;
        base_word = {48'h0, cfg.base_high, cfg.base_low};
        index     = {55'h0, cfg.chan_msb, cfg.chan_low};
        fine_n    = {40'h0, cfg.base_high, cfg.base_low, cfg.chan_low};
        hz = (base_word + index * {56'h0, cfg.spacing}) * `SCC_STEP_HZ;
        if (BAND_24G) begin
            hz = hz + `SCC_OFFSET_24G_HZ;
        end
        case (cfg.scheme)
            2'h1: if (!BAND_24G) begin
                hz = `SCC_FINE1_BASE_HZ
                   + ((`SCC_FINE1_REF_HZ * fine_n) >> `SCC_FINE_SHIFT);
            end
            2'h2: if (!BAND_24G) begin
                hz = `SCC_FINE2_BASE_HZ
                   + ((`SCC_FINE2_REF_HZ * fine_n) >> `SCC_FINE_SHIFT);
            end
            2'h3: if (BAND_24G) begin
                hz = `SCC_FINE3_BASE_HZ
                   + ((`SCC_FINE3_REF_HZ * fine_n) >> `SCC_FINE_SHIFT);
            end
            default: hz = hz;
        endcase
        return hz[31:0];
    endfunction : chan_freq

    logic [ADDR_W-1:0] aw_addr_ff;
    logic              aw_held_ff;
    logic [31:0]       w_data_ff;
    logic              w_strb0_ff;
    logic              w_held_ff;
    logic              wr_fire;
    scc_reg_sel_t      wr_sel;

    assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wr_sel  = reg_decode(aw_addr_ff);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            aw_held_ff    <= 1'b0;
            aw_addr_ff    <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff    <= 1'b1;
            aw_addr_ff    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_held_ff    <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_ff && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            w_held_ff    <= 1'b0;
            w_data_ff    <= '0;
            w_strb0_ff   <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff    <= 1'b1;
            w_data_ff    <= s_axi_wdata;
            w_strb0_ff   <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_held_ff    <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_ff && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == SCC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    scc_chan_cfg_t  stage_ff;
    scc_chan_cfg_t  active_ff;
    scc_chan_cfg_t  nxt_active;
    logic           commit;
    logic           wr_byte;

    // strobe lane 0 holds every byte-wide field
    assign wr_byte = wr_fire && w_strb0_ff;
    assign commit  = wr_byte && (wr_sel == SCC_SEL_MODE_APPLY);

    always_comb begin
        nxt_active          = stage_ff;
        nxt_active.scheme   = w_data_ff[`SCC_MODE_SCHEME_HI:`SCC_MODE_SCHEME_LO];
        nxt_active.chan_msb = w_data_ff[`SCC_MODE_MSB_BIT];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage_ff.spacing   <= `SCC_RST_SPACING;
            stage_ff.base_low  <= `SCC_RST_BASE_LOW;
            stage_ff.base_high <= `SCC_RST_BASE_HIGH;
            stage_ff.chan_low  <= `SCC_RST_CHAN_LOW;
            stage_ff.scheme    <= 2'(`SCC_RST_MODE_APPLY >> `SCC_MODE_SCHEME_LO);
            stage_ff.chan_msb  <= 1'b0;
        end else if (wr_byte) begin
            case (wr_sel)
                SCC_SEL_SPACING:    stage_ff.spacing   <= w_data_ff[7:0];
                SCC_SEL_BASE_LOW:   stage_ff.base_low  <= w_data_ff[7:0];
                SCC_SEL_BASE_HIGH:  stage_ff.base_high <= w_data_ff[7:0];
                SCC_SEL_CHAN_LOW:   stage_ff.chan_low  <= w_data_ff[7:0];
                SCC_SEL_MODE_APPLY: begin
                    stage_ff.scheme   <= nxt_active.scheme;
                    stage_ff.chan_msb <= nxt_active.chan_msb;
                end
                default: stage_ff.spacing <= stage_ff.spacing;
            endcase
        end
    end

    // active copy changes only on the commit write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            active_ff.spacing   <= `SCC_RST_SPACING;
            active_ff.base_low  <= `SCC_RST_BASE_LOW;
            active_ff.base_high <= `SCC_RST_BASE_HIGH;
            active_ff.chan_low  <= `SCC_RST_CHAN_LOW;
            active_ff.scheme    <= 2'(`SCC_RST_MODE_APPLY >> `SCC_MODE_SCHEME_LO);
            active_ff.chan_msb  <= 1'b0;
        end else if (commit) begin
            active_ff <= nxt_active;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            synth_freq_hz <= chan_freq({2'h0, 1'b0, `SCC_RST_CHAN_LOW,
                                        `SCC_RST_BASE_HIGH, `SCC_RST_BASE_LOW,
                                        `SCC_RST_SPACING});
        end else begin
            synth_freq_hz <= chan_freq(active_ff);
        end
    end

    scc_trx_state_t trx_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trx_ff <= SCC_TRX_IDLE_OFF;
        end else if (wr_byte && wr_sel == SCC_SEL_TRX_CTRL) begin
            trx_ff <= scc_trx_state_t'(w_data_ff[`SCC_TRX_STATE_HI:0]);
        end
    end

    assign trx_state = trx_ff;

    scc_lock_state_t lk_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             active_trx;
    logic             lock_ff;
    logic             retune_req;
    logic             blank_done_ff;

    assign active_trx = (trx_ff != SCC_TRX_IDLE_OFF);
    // a commit arriving two cycles before the frequency word updates is
    // caught here so the tuning starts from the new word
    assign retune_req = commit;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lk_ff         <= SCC_LK_OFF;
            cnt_ff        <= '0;
            blank_done_ff <= 1'b0;
        end else if (!active_trx) begin
            lk_ff         <= SCC_LK_OFF;
            cnt_ff        <= '0;
            blank_done_ff <= 1'b0;
        end else if (retune_req) begin
            lk_ff         <= SCC_LK_TUNING;
            cnt_ff        <= '0;
            blank_done_ff <= 1'b0;
        end else begin
            case (lk_ff)
                SCC_LK_OFF: begin
                    lk_ff         <= SCC_LK_TUNING;
                    cnt_ff        <= '0;
                    blank_done_ff <= 1'b0;
                end
                SCC_LK_TUNING: begin
                    // old lock may linger right after a retune
                    if (!blank_done_ff) begin
                        if (cnt_ff == CNT_W'(BLANK_CYC - 1)) begin
                            blank_done_ff <= 1'b1;
                            cnt_ff        <= '0;
                        end else begin
                            cnt_ff <= cnt_ff + 1'b1;
                        end
                    end else if (!pll_lock_in) begin
                        cnt_ff <= '0;
                    end else if (cnt_ff == CNT_W'(SETTLE_CYC - 1)) begin
                        lk_ff  <= SCC_LK_LOCKED;
                        cnt_ff <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                SCC_LK_LOCKED: begin
                    if (!pll_lock_in) begin
                        lk_ff <= SCC_LK_UNLOCKED;
                    end
                end
                SCC_LK_UNLOCKED: begin
                    if (pll_lock_in) begin
                        lk_ff <= SCC_LK_LOCKED;
                    end
                end
                default: lk_ff <= SCC_LK_OFF;
            endcase
        end
    end

    // event pulses, one cycle each
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ready_irq <= 1'b0;
            error_irq <= 1'b0;
        end else begin
            ready_irq <= active_trx && !retune_req &&
                         ((lk_ff == SCC_LK_TUNING && blank_done_ff && pll_lock_in
                           && cnt_ff == CNT_W'(SETTLE_CYC - 1)) ||
                          (lk_ff == SCC_LK_UNLOCKED && pll_lock_in));
            error_irq <= active_trx && !retune_req
                         && lk_ff == SCC_LK_LOCKED && !pll_lock_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            synth_enable <= 1'b0;
            synth_retune <= 1'b0;
            lock_ff      <= 1'b0;
        end else begin
            synth_enable <= active_trx;
            synth_retune <= active_trx && (retune_req || lk_ff == SCC_LK_OFF);
            lock_ff      <= active_trx && pll_lock_in;
        end
    end

    logic [31:0]  rd_word;
    scc_reg_sel_t rd_sel;

    assign rd_sel = reg_decode(s_axi_araddr);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            SCC_SEL_SPACING:    rd_word[7:0] = stage_ff.spacing;
            SCC_SEL_BASE_LOW:   rd_word[7:0] = stage_ff.base_low;
            SCC_SEL_BASE_HIGH:  rd_word[7:0] = stage_ff.base_high;
            SCC_SEL_CHAN_LOW:   rd_word[7:0] = stage_ff.chan_low;
            SCC_SEL_MODE_APPLY: begin
                rd_word[`SCC_MODE_SCHEME_HI:`SCC_MODE_SCHEME_LO] = stage_ff.scheme;
                rd_word[`SCC_MODE_MSB_BIT] = stage_ff.chan_msb;
            end
            SCC_SEL_SYNTH_STAT: begin
                rd_word[`SCC_STAT_LOCK_BIT] = lock_ff;
                rd_word[`SCC_STAT_BUSY_BIT] = (lk_ff == SCC_LK_TUNING);
            end
            SCC_SEL_TRX_CTRL:   rd_word[`SCC_TRX_STATE_HI:0] = trx_ff;
            default:            rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= (rd_sel == SCC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : scc_synth_channel_config
